// [pkg/tam_pkg.sv]
// Shared constants and state codes of the trace and RAM monitor port.
// Assumes a 32-bit system address space and a four-bit nibble link.
package tam_pkg;
    // ----------------------------------------
    // Link widths and nibble codes
    // ----------------------------------------
    localparam int          AW         = 32;
    localparam int          NW         = 4;
    localparam logic [3:0]  IDLE_NIB   = 4'h3;
    localparam logic [3:0]  HDR_BASE   = 4'h8;
    localparam logic [3:0]  NOT_READY  = 4'h0;
    localparam logic [3:0]  READY      = 4'h1;
    localparam logic [3:0]  CMD_ERR    = 4'h2;
    localparam logic [3:0]  BUS_ERR    = 4'h4;
    localparam logic [31:0] REF_INIT   = 32'h00000000;
    localparam logic [3:0]  ADDR_LAST  = 4'h7;
    // ----------------------------------------
    // Command nibble: bit 3 valid, bit 2 write, bits 1:0 size
    // ----------------------------------------
    localparam logic [1:0]  SZ_BYTE    = 2'h0;
    localparam logic [1:0]  SZ_WORD    = 2'h1;
    localparam logic [1:0]  SZ_LONG    = 2'h2;
    // ----------------------------------------
    // Address areas with special access limits
    // ----------------------------------------
    localparam logic [31:0] IO8_BASE   = 32'hffff8000;
    localparam logic [31:0] IO8_MASK   = 32'hfffff000;
    localparam logic [31:0] CAN_BASE   = 32'hffffd000;
    localparam logic [31:0] CAN_MASK   = 32'hfffff000;
    localparam logic [31:0] EXT_BASE   = 32'h00400000;
    localparam logic [31:0] EXT_MASK   = 32'hffc00000;
    // ----------------------------------------
    // State codes
    // ----------------------------------------
    typedef enum logic [0:0] {
        BT_IDLE = 1'b0,
        BT_ADDR = 1'b1
    } tam_bt_t;
    typedef enum logic [2:0] {
        RM_IDLE  = 3'b000,
        RM_ADDR  = 3'b001,
        RM_DATA  = 3'b010,
        RM_BUSY  = 3'b011,
        RM_READY = 3'b100,
        RM_RDATA = 3'b101
    } tam_rm_t;
endpackage

// [sim/tam_emu.sv]
// Emulator model: runs the link clock, resets the port, sends monitor frames.
// Assumes the bench samples the port outputs itself.
`timescale 1ns/100ps
module tam_emu (
    output logic       portClock,
    output logic       portResetN,
    output logic       modeSelectPin,
    output logic       frameSyncNIn,
    output logic [3:0] debugNibbleIn
);
    logic sending;
    initial begin
        {portClock, portResetN, modeSelectPin, frameSyncNIn, sending} = 5'h02;
        debugNibbleIn = 4'h0;
        forever #3 portClock = ~portClock;
    end
    // Released data lines toggle, so stale input never looks like a nibble
    always @(posedge portClock) if (!sending) debugNibbleIn <= ~debugNibbleIn;
    task automatic port_reset(input logic mode);
        @(posedge portClock);
        portResetN <= 1'b0;
        modeSelectPin <= mode;
        repeat (4) @(posedge portClock);
        portResetN <= 1'b1;
    endtask
    task automatic send(input logic [43:0] nibs, input int n);
        sending = 1'b1;
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge portClock);
            frameSyncNIn <= 1'b0;
            debugNibbleIn <= nibs[4*i+:4];
        end
        @(posedge portClock);
        sending = 1'b0;
    endtask
    task automatic end_frame;
        @(posedge portClock);
        frameSyncNIn <= 1'b1;
        repeat (4) @(posedge portClock);
    endtask
endmodule

// [sim/tb_top.sv]
// Bench: trace stream and monitor accesses through the emulator model.
// Assumes a one-clock bus slave; read data repeats one byte in every lane.
`timescale 1ns/100ps
module tb_top;
    logic        clk, nrst, softwarePortResetBit, moduleStopBit, hwStandby, swStandby;
    logic        singleChipMode, branchValid, busAck, busErr, busReq, busWrite;
    logic        portClock, portResetN, modeSelectPin, frameSyncNIn;
    logic        frameSyncNOut, frameSyncNOe, debugNibbleOe;
    logic [3:0]  debugNibbleIn, debugNibbleOut;
    logic [1:0]  busSize;
    logic [31:0] branchAddr, busAddr, busWdata, busRdata;
    int          errors, samples_checked;
    tam_port i_tam_port (.*);
    tam_emu  i_tam_emu (.*);
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) busAck <= busReq && !busAck;
    task automatic finish_test;
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Undriven sync counts as negated, undriven data as f; samples up to lim+1 link cycles for e
    task automatic expect_nib(input logic [4:0] e, input int lim);
        logic [4:0] seen;
        int k;
        k = 0;
        do begin
            @(negedge portClock);
            seen = {frameSyncNOe ? frameSyncNOut : 1'b1, debugNibbleOe ? debugNibbleOut : 4'hf};
            k++;
        end while (seen !== e && k <= lim);
        samples_checked++;
        if (seen !== e) begin
            errors++;
            $display("FAIL nibble expected %h seen %h", e, seen);
        end
    endtask
    task automatic branch(input logic [31:0] a);
        @(posedge clk);
        branchValid <= 1'b1;
        branchAddr <= a;
        @(posedge clk);
        branchValid <= 1'b0;
    endtask
    task automatic start(input logic mode);
        @(posedge clk);
        softwarePortResetBit <= 1'b0;
        i_tam_emu.port_reset(mode);
        @(posedge clk);
        softwarePortResetBit <= 1'b1;
        repeat (40) @(posedge portClock);
    endtask
    initial begin
        {nrst, softwarePortResetBit, moduleStopBit, hwStandby, swStandby} = 5'h00;
        {singleChipMode, branchValid, busErr} = 3'h0;
        branchAddr = 32'h0;
        busRdata = 32'h5a5a5a5a;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        start(1'b0);
        expect_nib(5'h13, 0);
        @(posedge clk);
        branchValid <= 1'b1;
        branchAddr <= 32'h12345678;
        @(posedge clk);
        branchAddr <= 32'h00000070;
        // Standby freezes the first frame so that the second branch cuts it
        @(posedge clk);
        branchValid <= 1'b0;
        swStandby <= 1'b1;
        repeat (10) @(posedge clk);
        swStandby <= 1'b0;
        expect_nib(5'h19, 40);
        expect_nib(5'h00, 0);
        expect_nib(5'h07, 0);
        expect_nib(5'h13, 0);
        branch(32'h00000074);
        expect_nib(5'h08, 20);
        expect_nib(5'h04, 0);
        expect_nib(5'h13, 0);
        start(1'b1);
        i_tam_emu.send(36'h800001000, 9);
        expect_nib(5'h10, 3);
        expect_nib(5'h11, 100);
        i_tam_emu.end_frame();
        expect_nib(5'h15, 4);
        expect_nib(5'h1a, 0);
        i_tam_emu.send(36'h300001000, 9);
        expect_nib(5'h13, 100);
        i_tam_emu.end_frame();
        i_tam_emu.send(36'h900001001, 9);
        expect_nib(5'h15, 100);
        i_tam_emu.end_frame();
        i_tam_emu.send(36'haffff8000, 9);
        expect_nib(5'h15, 100);
        i_tam_emu.end_frame();
        i_tam_emu.send(44'hc000020003c, 11);
        expect_nib(5'h11, 100);
        samples_checked++;
        if ({busWrite, busSize, busAddr, busWdata} !== {3'h4, 32'h2000, 32'h3c}) begin
            errors++;
            $display("FAIL bus write expected %h seen %h", {3'h4, 32'h2000, 32'h3c},
                     {busWrite, busSize, busAddr, busWdata});
        end
        i_tam_emu.end_frame();
        finish_test();
    end
    initial begin
        #100000;
        errors++;
        finish_test();
    end
endmodule

// [verilog/tam_port.sv]
// Debug nibble port: branch trace streamer and RAM monitor bus master.
// Assumes a bus slave answering busReq with busAck on clk, and the
// emulator clocking portClock, which is its own clock domain.
// How it works
// - Reset held with mode pin low selects branch trace at release.
// - Reset held with mode pin high selects RAM monitor at release.
// - Trace mode drives idle nibble 0011 every port clock without branches.
// - A branch asserts sync with a length header, then address nibbles.
// - Length comes from comparing destination with reference, initially zero.
// - Only a completely sent address becomes the new reference.
// - After the last address nibble sync negates and idle nibble returns.
// - A branch during output restarts with a new header, sync negated.
// - Header should follow the branch by about two port clocks; the two sync flops make it two to three.
// - Monitor input nibbles are taken only while emulator asserts sync.
// - A full command, address and write data start one bus access.
// - Not ready 0000 while the access runs, ready 0001 when done.
// - After ready, sync negation by emulator starts read data output.
// - Undefined command skips access and sets flag bit 1.
// - Bus error abandons access and sets flag bit 2.
// - Misaligned word or longword addresses count as bus errors.
// - Longword to 8-bit or CAN area, external in single-chip: errors.
// - Power-on, hardware standby, reset pin, software bit, module stop clear all.
// - Software standby freezes trace output and blocks new branches and bus accesses without clearing.
`timescale 1ns/100ps
module tam_port (
    input  wire logic                  clk,
    input  wire logic                  nrst,
    input  wire logic                  portClock,
    input  wire logic                  portResetN,
    input  wire logic                  modeSelectPin,
    input  wire logic                  frameSyncNIn,
    output logic                       frameSyncNOut,
    output logic                       frameSyncNOe,
    input  wire logic [tam_pkg::NW-1:0] debugNibbleIn,
    output logic [tam_pkg::NW-1:0]     debugNibbleOut,
    output logic                       debugNibbleOe,
    input  wire logic                  softwarePortResetBit,
    input  wire logic                  moduleStopBit,
    input  wire logic                  hwStandby,
    input  wire logic                  swStandby,
    input  wire logic                  singleChipMode,
    input  wire logic                  branchValid,
    input  wire logic [tam_pkg::AW-1:0] branchAddr,
    output logic                       busReq,
    output logic                       busWrite,
    output logic [tam_pkg::AW-1:0]     busAddr,
    output logic [1:0]                 busSize,
    output logic [tam_pkg::AW-1:0]     busWdata,
    input  wire logic                  busAck,
    input  wire logic                  busErr,
    input  wire logic [tam_pkg::AW-1:0] busRdata
);
    import tam_pkg::*;

    // ----------------------------------------
    // State records
    // ----------------------------------------
    typedef struct packed {
        logic        clr;
        logic        brBusy;
        logic        brPend;
        logic [31:0] pendAddr;
        logic [31:0] xfrAddr;
        logic        brReq;
        logic        accSeen;
        logic        accBusy;
        logic        done;
        logic        err;
        logic [31:0] rdata;
        logic        busReq;
        logic        busWrite;
        logic [31:0] busAddr;
        logic [1:0]  busSize;
        logic [31:0] busWdata;
    } tam_sys_t;

    typedef struct packed {
        logic        mode;
        tam_bt_t     bt;
        tam_rm_t     rm;
        logic [3:0]  cnt;
        logic [2:0]  last;
        logic [31:0] shAddr;
        logic [31:0] refAddr;
        logic        brAck;
        logic        accReq;
        logic        doneSeen;
        logic [3:0]  cmd;
        logic [31:0] accAddr;
        logic [31:0] accData;
        logic [31:0] rdata;
        logic [3:0]  nibOut;
        logic        nibOe;
        logic        syncNOut;
        logic        syncOe;
    } tam_link_t;

    tam_sys_t  sr_reg;
    tam_sys_t  sr_next;
    tam_link_t lr_reg;
    tam_link_t lr_next;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic inArea(input logic [31:0] a,
                                    input logic [31:0] base,
                                    input logic [31:0] mask);
        inArea = (a & mask) == base;
    endfunction

    function automatic logic cmdOk(input logic [3:0] c);
        cmdOk = c[3] && (c[1:0] != 2'h3);
    endfunction

    function automatic logic [2:0] dataLast(input logic [1:0] sz);
        unique case (sz)
            SZ_BYTE: dataLast = 3'h1;
            SZ_WORD: dataLast = 3'h3;
            default: dataLast = 3'h7;
        endcase
    endfunction

    function automatic logic [1:0] lenOf(input logic [31:0] d);
        if (d[31:4] == 28'h0)       lenOf = 2'h0;
        else if (d[31:8] == 24'h0)  lenOf = 2'h1;
        else if (d[31:16] == 16'h0) lenOf = 2'h2;
        else                        lenOf = 2'h3;
    endfunction

    function automatic logic [3:0] nibOf(input logic [31:0] w,
                                         input logic [2:0]  i);
        nibOf = w[{i, 2'b00} +: 4];
    endfunction

    function automatic logic accFault(input logic [1:0]  sz,
                                      input logic [31:0] a,
                                      input logic        single);
        logic long;
        long = (sz == SZ_LONG);
        accFault = ((sz == SZ_WORD) && a[0])
                 || (long && (a[1:0] != 2'h0))
                 || (long && inArea(a, IO8_BASE, IO8_MASK))
                 || (long && inArea(a, CAN_BASE, CAN_MASK))
                 || (single && inArea(a, EXT_BASE, EXT_MASK));
    endfunction

    // ----------------------------------------
    // Crossings
    // ----------------------------------------
    // Words cross under toggle handshakes: the holder keeps them
    // stable until the far side has acknowledged.
    logic [10:0] lSync1;
    logic [10:0] lSync2;
    logic [2:0]  sSync1;
    logic [2:0]  sSync2;

    always_ff @(posedge portClock) begin
        lSync1 <= {sr_reg.clr, portResetN, modeSelectPin, frameSyncNIn,
                   debugNibbleIn, sr_reg.brReq, sr_reg.done, swStandby};
        lSync2 <= lSync1;
    end

    always_ff @(posedge clk) begin
        sSync1 <= {lr_reg.accReq, lr_reg.brAck, portResetN};
        sSync2 <= sSync1;
    end

    logic       lClr;
    logic       sMode;
    logic       syncOn;
    logic [3:0] sNib;
    logic       sBrReq;
    logic       sDone;
    logic       sStby;
    logic       brEv;
    logic       sLinkReq;
    logic       sBrAck;
    logic       sPortRst;

    assign lClr     = lSync2[10] || !lSync2[9];
    assign sMode    = lSync2[8];
    assign syncOn   = !lSync2[7];
    assign sNib     = lSync2[6:3];
    assign sBrReq   = lSync2[2];
    assign sDone    = lSync2[1];
    assign sStby    = lSync2[0];
    // Two sync flops stretch the header delay past two port clocks
    assign brEv     = (sBrReq != lr_reg.brAck) && !lr_reg.mode;
    assign sLinkReq = sSync2[2];
    assign sBrAck   = sSync2[1];
    assign sPortRst = !sSync2[0];

    // ----------------------------------------
    // System side: branch capture and bus master
    // ----------------------------------------
    always_comb begin
        logic clrNow;
        clrNow = !softwarePortResetBit || moduleStopBit
               || hwStandby || sPortRst;
        sr_next = sr_reg;
        if (sr_reg.clr) begin
            sr_next = '0;
        end else begin
            if (sr_reg.brBusy && (sBrAck == sr_reg.brReq)) begin
                sr_next.brBusy = 1'b0;
            end
            if (!sr_next.brBusy && sr_reg.brPend) begin
                sr_next.brPend  = 1'b0;
                sr_next.xfrAddr = sr_reg.pendAddr;
                sr_next.brReq   = !sr_reg.brReq;
                sr_next.brBusy  = 1'b1;
            end
            // Only the newest waiting branch is kept; older ones are
            // superseded exactly as the link itself would drop them.
            if (branchValid && !swStandby) begin
                if (sr_next.brBusy) begin
                    sr_next.brPend   = 1'b1;
                    sr_next.pendAddr = branchAddr;
                end else begin
                    sr_next.xfrAddr = branchAddr;
                    sr_next.brReq   = !sr_reg.brReq;
                    sr_next.brBusy  = 1'b1;
                end
            end
            if ((sLinkReq != sr_reg.accSeen) && !sr_reg.accBusy
                    && !swStandby) begin
                sr_next.accSeen  = sLinkReq;
                sr_next.busAddr  = lr_reg.accAddr;
                sr_next.busSize  = lr_reg.cmd[1:0];
                sr_next.busWrite = lr_reg.cmd[2];
                sr_next.busWdata = lr_reg.accData;
                if (accFault(lr_reg.cmd[1:0], lr_reg.accAddr,
                             singleChipMode)) begin
                    sr_next.err  = 1'b1;
                    sr_next.done = !sr_reg.done;
                end else begin
                    sr_next.err     = 1'b0;
                    sr_next.busReq  = 1'b1;
                    sr_next.accBusy = 1'b1;
                end
            end else if (sr_reg.accBusy && busAck) begin
                sr_next.busReq  = 1'b0;
                sr_next.accBusy = 1'b0;
                sr_next.rdata   = busRdata;
                sr_next.err     = busErr;
                sr_next.done    = !sr_reg.done;
            end
        end
        sr_next.clr = clrNow;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            sr_reg <= '{clr: 1'b1, default: '0};
        end else begin
            sr_reg <= sr_next;
        end
    end

    assign busReq   = sr_reg.busReq;
    assign busWrite = sr_reg.busWrite;
    assign busAddr  = sr_reg.busAddr;
    assign busSize  = sr_reg.busSize;
    assign busWdata = sr_reg.busWdata;

    // ----------------------------------------
    // Link side: trace streamer and monitor protocol
    // ----------------------------------------
    always_comb begin
        logic [1:0] len;
        logic       go;
        len     = 2'h0;
        go      = 1'b0;
        lr_next = lr_reg;
        if (lClr) begin
            lr_next          = '0;
            lr_next.mode     = sMode;
            lr_next.refAddr  = REF_INIT;
            lr_next.syncNOut = 1'b1;
        end else if (!lr_reg.mode) begin
            lr_next.nibOe  = 1'b1;
            lr_next.syncOe = 1'b1;
            if (sStby) begin
                lr_next = lr_reg;
            end else if (brEv) begin
                len              = lenOf(sr_reg.xfrAddr ^ lr_reg.refAddr);
                lr_next.brAck    = sBrReq;
                lr_next.shAddr   = sr_reg.xfrAddr;
                lr_next.last     = 3'((4'h1 << len) - 4'h1);
                lr_next.nibOut   = HDR_BASE | {2'b00, len};
                lr_next.syncNOut = (lr_reg.bt == BT_ADDR);
                lr_next.cnt      = 4'h0;
                lr_next.bt       = BT_ADDR;
            end else if (lr_reg.bt == BT_ADDR) begin
                lr_next.syncNOut = 1'b0;
                lr_next.nibOut   = nibOf(lr_reg.shAddr, lr_reg.cnt[2:0]);
                lr_next.cnt      = lr_reg.cnt + 4'h1;
                if (lr_reg.cnt[2:0] == lr_reg.last) begin
                    lr_next.bt      = BT_IDLE;
                    lr_next.refAddr = lr_reg.shAddr;
                end
            end else begin
                lr_next.nibOut   = IDLE_NIB;
                lr_next.syncNOut = 1'b1;
            end
        end else begin
            lr_next.syncOe = 1'b0;
            unique case (lr_reg.rm)
                RM_IDLE: begin
                    lr_next.nibOe = 1'b0;
                    if (syncOn) begin
                        lr_next.cmd = sNib;
                        lr_next.cnt = 4'h0;
                        lr_next.rm  = RM_ADDR;
                    end
                end
                RM_ADDR: begin
                    if (syncOn) begin
                        lr_next.accAddr = {lr_reg.accAddr[27:0], sNib};
                        lr_next.cnt     = lr_reg.cnt + 4'h1;
                        if (lr_reg.cnt == ADDR_LAST) begin
                            lr_next.cnt  = 4'h0;
                            lr_next.last = dataLast(lr_reg.cmd[1:0]);
                            if (cmdOk(lr_reg.cmd) && lr_reg.cmd[2]) begin
                                lr_next.rm = RM_DATA;
                            end else begin
                                go = 1'b1;
                            end
                        end
                    end
                end
                RM_DATA: begin
                    if (syncOn) begin
                        lr_next.accData = {lr_reg.accData[27:0], sNib};
                        lr_next.cnt     = lr_reg.cnt + 4'h1;
                        if (lr_reg.cnt[2:0] == lr_reg.last) begin
                            go = 1'b1;
                        end
                    end
                end
                RM_BUSY: begin
                    // Software standby keeps the system side from starting the access, so this
                    // keeps answering not ready; an access already started still completes.
                    lr_next.nibOut = NOT_READY;
                    if (sDone != lr_reg.doneSeen) begin
                        lr_next.doneSeen = sDone;
                        lr_next.rdata    = sr_reg.rdata;
                        lr_next.nibOut   = READY
                                         | (sr_reg.err ? BUS_ERR : 4'h0);
                        lr_next.cmd[3]   = !sr_reg.err;
                        lr_next.rm       = RM_READY;
                    end
                end
                RM_READY: begin
                    if (!syncOn) begin
                        lr_next.cnt = 4'h0;
                        if (lr_reg.cmd[3] && !lr_reg.cmd[2]) begin
                            lr_next.rm = RM_RDATA;
                        end else begin
                            lr_next.nibOe = 1'b0;
                            lr_next.rm    = RM_IDLE;
                        end
                    end
                end
                RM_RDATA: begin
                    if (lr_reg.cnt > {1'b0, lr_reg.last}) begin
                        lr_next.nibOe = 1'b0;
                        lr_next.rm    = RM_IDLE;
                    end else begin
                        lr_next.nibOut = nibOf(lr_reg.rdata,
                                               lr_reg.last - lr_reg.cnt[2:0]);
                        lr_next.cnt    = lr_reg.cnt + 4'h1;
                    end
                end
                default: lr_next.rm = RM_IDLE;
            endcase
            if (go) begin
                lr_next.nibOe = 1'b1;
                if (cmdOk(lr_reg.cmd)) begin
                    lr_next.accReq = !lr_reg.accReq;
                    lr_next.nibOut = NOT_READY;
                    lr_next.rm     = RM_BUSY;
                end else begin
                    lr_next.cmd[3] = 1'b0;
                    lr_next.nibOut = READY | CMD_ERR;
                    lr_next.rm     = RM_READY;
                end
            end
        end
    end

    // Link state has no reset of its own: the synchronised clear holds
    // it while the emulator clocks the port with its reset pin low.
    always_ff @(posedge portClock) begin
        lr_reg <= lr_next;
    end

    assign frameSyncNOut  = lr_reg.syncNOut;
    assign frameSyncNOe   = lr_reg.syncOe;
    assign debugNibbleOut = lr_reg.nibOut;
    assign debugNibbleOe  = lr_reg.nibOe;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence lastNibS;
        !lr_reg.mode && lr_reg.bt == BT_ADDR && !sStby && !brEv
            && lr_reg.cnt[2:0] == lr_reg.last;
    endsequence

    sequence quietS;
        !brEv && !sStby;
    endsequence

    mode_latch_a: assert property (@(posedge portClock)
        $fell(lClr) |-> lr_reg.mode == $past(sMode))
        else $error("mode not taken at reset release");

    idle_nib_a: assert property (@(posedge portClock) disable iff (lClr)
        !lr_reg.mode && lr_reg.bt == BT_IDLE && !brEv && !sStby
            |=> debugNibbleOut == IDLE_NIB && frameSyncNOut)
        else $error("idle nibble missing");

    header_a: assert property (@(posedge portClock) disable iff (lClr)
        brEv && !sStby |=> debugNibbleOut[3:2] == 2'b10
            && debugNibbleOut[1:0] == lenOf(lr_reg.shAddr ^ $past(lr_reg.refAddr)))
        else $error("bad length header");

    ref_update_a: assert property (@(posedge portClock) disable iff (lClr)
        $changed(lr_reg.refAddr) |-> $past(lr_reg.bt) == BT_ADDR
            && $past(lr_reg.cnt[2:0]) == $past(lr_reg.last))
        else $error("reference set by partial address");

    frame_end_a: assert property (@(posedge portClock) disable iff (lClr)
        lastNibS ##1 quietS |=> frameSyncNOut && debugNibbleOut == IDLE_NIB)
        else $error("frame not closed");

    reheader_a: assert property (@(posedge portClock) disable iff (lClr)
        brEv && !sStby && lr_reg.bt == BT_ADDR
            |=> frameSyncNOut && debugNibbleOut[3:2] == 2'b10)
        else $error("no restart on new branch");

    sync_latch_a: assert property (@(posedge portClock) disable iff (lClr)
        lr_reg.mode && !syncOn && lr_reg.rm inside {RM_ADDR, RM_DATA}
            |=> $stable(lr_reg.accAddr) && $stable(lr_reg.accData))
        else $error("input taken without sync");

    not_ready_a: assert property (@(posedge portClock) disable iff (lClr)
        lr_reg.mode && lr_reg.rm == RM_BUSY && sDone == lr_reg.doneSeen
            |=> debugNibbleOut == NOT_READY && debugNibbleOe)
        else $error("not ready missing");

    ready_a: assert property (@(posedge portClock) disable iff (lClr)
        lr_reg.mode && lr_reg.rm == RM_BUSY && sDone != lr_reg.doneSeen
            |=> debugNibbleOut[0] && debugNibbleOut[2] == $past(sr_reg.err))
        else $error("ready flag wrong");

    cmd_err_a: assert property (@(posedge portClock) disable iff (lClr)
        lr_reg.mode && lr_reg.rm == RM_ADDR && syncOn && lr_reg.cnt == ADDR_LAST
            && !cmdOk(lr_reg.cmd)
            |=> debugNibbleOut == (READY | CMD_ERR) && $stable(lr_reg.accReq))
        else $error("command error not flagged");

    misalign_a: assert property (@(posedge clk) disable iff (sr_reg.clr)
        sLinkReq != sr_reg.accSeen && !sr_reg.accBusy && !swStandby
            && lr_reg.cmd[1:0] == SZ_WORD && lr_reg.accAddr[0]
            |=> !busReq && sr_reg.err)
        else $error("misaligned access issued");
endmodule
